// ### rtl/evr_pkg.sv
package evr_pkg;

  // source counts
  localparam int EVR_N_EXT = 22;
  localparam int EVR_N_INT = 3;
  localparam int EVR_N_SRC = EVR_N_EXT + EVR_N_INT;

  // apb geometry
  localparam int EVR_AW = 8;
  localparam int EVR_DW = 32;

  // register byte offsets
  localparam logic [EVR_AW-1:0] EVR_OFS_POL = 8'h00;
  localparam logic [EVR_AW-1:0] EVR_OFS_TYPE = 8'h04;
  localparam logic [EVR_AW-1:0] EVR_OFS_ROUTE_EN = 8'h08;
  localparam logic [EVR_AW-1:0] EVR_OFS_STATUS = 8'h0C;
  localparam logic [EVR_AW-1:0] EVR_OFS_IRQ_MASK = 8'h10;
  localparam logic [EVR_AW-1:0] EVR_OFS_LEVEL = 8'h14;
  localparam logic [EVR_AW-1:0] EVR_OFS_ROUTED = 8'h18;

  // field positions inside the source vector
  localparam int EVR_POS_EXT_IRQ = 0;
  localparam int EVR_POS_PERIPH = 8;
  localparam int EVR_POS_INTERNAL = 22;

  // reset values: ext_irq_in and internal sources active high, peripheral pins active low
  localparam logic [EVR_N_SRC-1:0] EVR_RST_POL = 25'h1C0_00FF;
  localparam logic [EVR_N_SRC-1:0] EVR_RST_TYPE = 25'h000_0000;
  localparam logic [EVR_N_SRC-1:0] EVR_RST_ROUTE_EN = 25'h000_0000;
  localparam logic [EVR_N_SRC-1:0] EVR_RST_STATUS = 25'h000_0000;
  localparam logic [EVR_N_SRC-1:0] EVR_RST_IRQ_MASK = 25'h000_0000;

  // apb slave answers in the first access cycle
  localparam int EVR_APB_WAIT_CYCLES = 0;

  // register selector
  typedef enum logic [2:0] {
    EVR_SEL_POL = 3'b000,
    EVR_SEL_TYPE = 3'b001,
    EVR_SEL_ROUTE_EN = 3'b010,
    EVR_SEL_STATUS = 3'b011,
    EVR_SEL_IRQ_MASK = 3'b100,
    EVR_SEL_LEVEL = 3'b101,
    EVR_SEL_ROUTED = 3'b110,
    EVR_SEL_NONE = 3'b111
  } evr_sel_t;

endpackage : evr_pkg

// ### rtl/evr_edge_cell.sv
`timescale 1ns/1ps

// clockless edge catcher: flips its toggle on every active edge of the event
module evr_edge_cell (
  // event side
  input wire logic evt_in,
  input wire logic pol,
  // reset and result
  input wire logic rstn,
  output logic tog
);

  logic act;
  logic tog_nxt;

  // active level after polarity: high input with pol 1, low input with pol 0
  assign act = ~(evt_in ^ pol);

  // next toggle value
  always_comb begin
    tog_nxt = ~tog;
  end

  // the event itself clocks this flop, so no running clock is needed
  always_ff @(posedge act or negedge rstn) begin
    if (!rstn) begin
      tog <= 1'b0;
    end else begin
      tog <= tog_nxt;
    end
  end

endmodule : evr_edge_cell

// ### rtl/evr_top.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps

module evr_top
  import evr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire logic [EVR_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [EVR_DW-1:0] pwdata,
  output logic [EVR_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources
  input wire logic [7:0] ext_irq_in,
  input wire logic [EVR_N_EXT-9:0] periph_evt_in,
  input wire logic [EVR_N_INT-1:0] int_evt_in,
  // requests to the vector_irq_ctrl
  output logic [EVR_N_SRC-1:0] vector_irq_ctrl_req,
  output logic clk_wake,
  // bus interrupt
  output logic irq
);

  // ------------------------------------------------------------------
  // address decode shared by read and write paths
  function automatic evr_sel_t evr_decode(input logic [EVR_AW-1:0] addr);
    evr_sel_t sel;
    sel = EVR_SEL_NONE;
    unique case (addr)
      EVR_OFS_POL: sel = EVR_SEL_POL;
      EVR_OFS_TYPE: sel = EVR_SEL_TYPE;
      EVR_OFS_ROUTE_EN: sel = EVR_SEL_ROUTE_EN;
      EVR_OFS_STATUS: sel = EVR_SEL_STATUS;
      EVR_OFS_IRQ_MASK: sel = EVR_SEL_IRQ_MASK;
      EVR_OFS_LEVEL: sel = EVR_SEL_LEVEL;
      EVR_OFS_ROUTED: sel = EVR_SEL_ROUTED;
      default: sel = EVR_SEL_NONE;
    endcase
    return sel;
  endfunction : evr_decode

  // zero-extend a source vector onto the data bus
  function automatic logic [EVR_DW-1:0] evr_widen(input logic [EVR_N_SRC-1:0] v);
    return {{(EVR_DW - EVR_N_SRC){1'b0}}, v};
  endfunction : evr_widen

  // ------------------------------------------------------------------
  // source vector and configuration

  logic [EVR_N_SRC-1:0] src_raw;
  logic [EVR_N_SRC-1:0] pol_r;
  logic [EVR_N_SRC-1:0] pol_nxt;
  logic [EVR_N_SRC-1:0] type_r;
  logic [EVR_N_SRC-1:0] type_nxt;
  logic [EVR_N_SRC-1:0] route_en_r;
  logic [EVR_N_SRC-1:0] route_en_nxt;
  logic [EVR_N_SRC-1:0] irq_mask_r;
  logic [EVR_N_SRC-1:0] irq_mask_nxt;
  logic [EVR_N_SRC-1:0] status_r;
  logic [EVR_N_SRC-1:0] status_nxt;
  logic [EVR_N_SRC-1:0] seen_r;
  logic [EVR_N_SRC-1:0] seen_nxt;

  // gather pins and internal sources into one vector
  assign src_raw = {int_evt_in, periph_evt_in, ext_irq_in};

  // ------------------------------------------------------------------
  // clockless detection

  logic [EVR_N_SRC-1:0] tog_raw;
  logic [EVR_N_SRC-1:0] active_raw;
  logic [EVR_N_SRC-1:0] latch_raw;
  logic [EVR_N_SRC-1:0] req_raw;

  // one edge catcher per source
  genvar gi;
  generate
    for (gi = 0; gi < EVR_N_SRC; gi++) begin : g_cell
      evr_edge_cell u_cell (
        .evt_in(src_raw[gi]),
        .pol(pol_r[gi]),
        .rstn(rstn),
        .tog(tog_raw[gi])
      );
    end
  endgenerate

  // active level per polarity, async path
  assign active_raw = ~(src_raw ^ pol_r);
  // latched request: held status, or an edge not yet seen by the clock
  assign latch_raw = status_r | (tog_raw ^ seen_r);
  // direct follows the level, latched holds until cleared
  assign req_raw = type_r & latch_raw | ~type_r & active_raw;

  // routed requests, high when asserted, gated per source
  assign vector_irq_ctrl_req = route_en_r & req_raw;
  // any enabled request may restart a stopped clock
  assign clk_wake = |vector_irq_ctrl_req;

  // ------------------------------------------------------------------
  // synchronisers into ref_clk for readback and status

  logic [EVR_N_SRC-1:0] tog_s1_r;
  logic [EVR_N_SRC-1:0] tog_s2_r;
  logic [EVR_N_SRC-1:0] lvl_s1_r;
  logic [EVR_N_SRC-1:0] lvl_s2_r;
  logic [EVR_N_SRC-1:0] req_s1_r;
  logic [EVR_N_SRC-1:0] req_s2_r;

  // two flops per crossing; only the second stage is read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tog_s1_r <= '0;
      tog_s2_r <= '0;
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
      req_s1_r <= '0;
      req_s2_r <= '0;
    end else begin
      tog_s1_r <= tog_raw;
      tog_s2_r <= tog_s1_r;
      lvl_s1_r <= active_raw;
      lvl_s2_r <= lvl_s1_r;
      req_s1_r <= vector_irq_ctrl_req;
      req_s2_r <= req_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // apb decode

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  evr_sel_t sel;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite;
  assign sel = evr_decode(paddr);

  // zero-wait slave, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = access_ph & (sel == EVR_SEL_NONE);

  // ------------------------------------------------------------------
  // configuration and status next values

  logic [EVR_N_SRC-1:0] new_edge;
  logic [EVR_N_SRC-1:0] wdata_src;

  assign new_edge = tog_s2_r ^ seen_r;
  assign wdata_src = pwdata[EVR_N_SRC-1:0];

  always_comb begin
    pol_nxt = pol_r;
    type_nxt = type_r;
    route_en_nxt = route_en_r;
    irq_mask_nxt = irq_mask_r;
    status_nxt = status_r;
    seen_nxt = tog_s2_r;
    // write-one-to-clear of the latch status
    if (wr_en && sel == EVR_SEL_STATUS) begin
      status_nxt = status_r & ~wdata_src;
    end
    // a fresh edge in the clearing cycle wins over the clear
    status_nxt = status_nxt | new_edge;
    if (wr_en) begin
      unique case (sel)
        EVR_SEL_POL: pol_nxt = wdata_src;
        EVR_SEL_TYPE: type_nxt = wdata_src;
        EVR_SEL_ROUTE_EN: route_en_nxt = wdata_src;
        EVR_SEL_IRQ_MASK: irq_mask_nxt = wdata_src;
        EVR_SEL_STATUS, EVR_SEL_LEVEL, EVR_SEL_ROUTED, EVR_SEL_NONE: begin
        end
      endcase
    end
  end

  // configuration and status registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pol_r <= EVR_RST_POL;
      type_r <= EVR_RST_TYPE;
      route_en_r <= EVR_RST_ROUTE_EN;
      irq_mask_r <= EVR_RST_IRQ_MASK;
      status_r <= EVR_RST_STATUS;
      seen_r <= '0;
    end else begin
      pol_r <= pol_nxt;
      type_r <= type_nxt;
      route_en_r <= route_en_nxt;
      irq_mask_r <= irq_mask_nxt;
      status_r <= status_nxt;
      seen_r <= seen_nxt;
    end
  end

  // ------------------------------------------------------------------
  // read data, captured in the setup phase

  logic [EVR_DW-1:0] prdata_nxt;

  always_comb begin
    prdata_nxt = prdata;
    if (setup_ph && !pwrite) begin
      unique case (sel)
        EVR_SEL_POL: prdata_nxt = evr_widen(pol_r);
        EVR_SEL_TYPE: prdata_nxt = evr_widen(type_r);
        EVR_SEL_ROUTE_EN: prdata_nxt = evr_widen(route_en_r);
        EVR_SEL_STATUS: prdata_nxt = evr_widen(status_r);
        EVR_SEL_IRQ_MASK: prdata_nxt = evr_widen(irq_mask_r);
        EVR_SEL_LEVEL: prdata_nxt = evr_widen(lvl_s2_r);
        EVR_SEL_ROUTED: prdata_nxt = evr_widen(req_s2_r);
        EVR_SEL_NONE: prdata_nxt = '0;
      endcase
    end
  end

  // read data register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ------------------------------------------------------------------
  // level interrupt while an unmasked status bit is set

  logic irq_nxt;

  always_comb begin
    irq_nxt = |(status_r & irq_mask_r);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

endmodule : evr_top

// ### tb/evr_vic_model.sv
`timescale 1ns/1ps

// far-side stand-in: sees requests and catches wake edges with no clock
module evr_vic_model
  import evr_pkg::*;
(
  // routed side
  input wire logic [EVR_N_SRC-1:0] req,
  input wire logic clk_wake,
  input wire logic ack,
  // observed
  output logic woke,
  output logic any_req
);
  // a high level is a pending request
  assign any_req = |req;
  // clock restart catcher, needs no running clock
  always_ff @(posedge clk_wake or posedge ack) begin
    if (ack) begin
      woke <= 1'b0;
    end else begin
      woke <= 1'b1;
    end
  end
endmodule : evr_vic_model

// ### tb/evr_top_props.sv
`timescale 1ns/1ps

module evr_top_props
  import evr_pkg::*;
(
  // clock, reset, apb
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [EVR_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [EVR_DW-1:0] pwdata,
  input wire logic [EVR_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and requests
  input wire logic [7:0] ext_irq_in,
  input wire logic [EVR_N_EXT-9:0] periph_evt_in,
  input wire logic [EVR_N_INT-1:0] int_evt_in,
  input wire logic [EVR_N_SRC-1:0] vector_irq_ctrl_req,
  input wire logic clk_wake,
  input wire logic irq
);
  logic [EVR_N_SRC-1:0] pol_r, typ_r, en_r, src;
  logic wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // source vector and write strobe
  assign src = {int_evt_in, periph_evt_in, ext_irq_in};
  assign wr = psel && penable && pwrite && pready;
  // shadow of the configuration written over the bus
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pol_r <= EVR_RST_POL;
      typ_r <= '0;
      en_r <= '0;
    end else if (wr) begin
      if (paddr == EVR_OFS_POL) pol_r <= pwdata[EVR_N_SRC-1:0];
      if (paddr == EVR_OFS_TYPE) typ_r <= pwdata[EVR_N_SRC-1:0];
      if (paddr == EVR_OFS_ROUTE_EN) en_r <= pwdata[EVR_N_SRC-1:0];
    end
  end
  chk_wake_or: assert property (clk_wake == |vector_irq_ctrl_req)
    else $error("wake output differs from request or");
  chk_mask_gate: assert property ((vector_irq_ctrl_req & ~en_r) == '0)
    else $error("request seen on disabled source");
  chk_direct_follow: assert property (
    ((en_r & ~typ_r) & (vector_irq_ctrl_req ^ ~(src ^ pol_r))) == '0)
    else $error("direct request does not follow pin");
  chk_latch_hold: assert property (
    |(typ_r & en_r & $past(vector_irq_ctrl_req) & ~vector_irq_ctrl_req)
    |-> $past(wr && paddr == EVR_OFS_STATUS)) else $error("latched request dropped");
  chk_reset_quiet: assert property ($rose(rstn) |-> !irq && vector_irq_ctrl_req == '0)
    else $error("activity right after reset");
  chk_irq_off: assert property (
    wr && paddr == EVR_OFS_IRQ_MASK && pwdata[24:0] == '0 |-> ##2 !irq)
    else $error("irq stays with mask cleared");
  chk_unmapped_err: assert property (psel && penable && paddr > EVR_OFS_ROUTED |-> pslverr)
    else $error("no error on unmapped address");
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  chk_upper_zero: assert property (prdata[31:25] == 7'h00)
    else $error("unused read bits set");
  cov_status_clr: cover property (wr && paddr == EVR_OFS_STATUS ##1 !vector_irq_ctrl_req[3]);
  cov_irq: cover property ($rose(irq));
  cov_err: cover property (pslverr);
endmodule : evr_top_props

bind evr_top evr_top_props props (.*);

// ### tb/test_event_router.sv
`timescale 1ns/1ps

module test_event_router
  import evr_pkg::*;
;
  logic ref_clk = 0, rstn = 0, run = 1, ack = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, clk_wake, irq, woke, any_req, err;
  logic [7:0] ext_irq_in = 0;
  logic [13:0] periph_evt_in = '1;
  logic [2:0] int_evt_in = 0;
  logic [24:0] vector_irq_ctrl_req, pol, en, exp;
  int bad_count = 0, checked = 0;
  // clock, can be held still
  initial begin
    forever #2.5 ref_clk = run ? ~ref_clk : ref_clk;
  end
  evr_top dut (.*);
  evr_vic_model vic (.req(vector_irq_ctrl_req), .clk_wake(clk_wake), .ack(ack),
    .woke(woke), .any_req(any_req));
  // compare and count
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask : check
  // one apb transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // direct request expected from pins, polarity and enable
  function automatic logic [24:0] exp_dir(logic [24:0] s, logic [24:0] p, logic [24:0] e);
    return e & ~(s ^ p);
  endfunction : exp_dir
  // verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(55));
    ack <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    ack <= 1'b0;
    apb(1'b0, EVR_OFS_POL, 32'h0000_0000);
    check("pol_rst", rd, 32'h01C0_00FF);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check("unmapped", {rd[30:0], err}, 32'h0000_0001);
    // random direct traffic
    repeat (20) begin
      pol = 25'($urandom);
      en = 25'($urandom);
      apb(1'b1, EVR_OFS_POL, {7'h00, pol});
      apb(1'b1, EVR_OFS_ROUTE_EN, {7'h00, en});
      @(posedge ref_clk);
      {int_evt_in, periph_evt_in, ext_irq_in} <= 25'($urandom);
      @(negedge ref_clk);
      exp = exp_dir({int_evt_in, periph_evt_in, ext_irq_in}, pol, en);
      check("direct", vector_irq_ctrl_req, exp);
      check("wake", clk_wake, |exp);
    end
    // latched mode, quiet pins, clean status
    apb(1'b1, EVR_OFS_ROUTE_EN, 32'h0000_0000);
    apb(1'b1, EVR_OFS_POL, 32'h01C0_00FF);
    {int_evt_in, periph_evt_in, ext_irq_in} <= 25'h03F_FF00;
    apb(1'b1, EVR_OFS_TYPE, 32'h01FF_FFFF);
    repeat (5) @(posedge ref_clk);
    apb(1'b1, EVR_OFS_STATUS, 32'h01FF_FFFF);
    apb(1'b1, EVR_OFS_ROUTE_EN, 32'h01FF_FFFF);
    ack <= 1'b1;
    @(negedge ref_clk);
    check("quiet", vector_irq_ctrl_req, 32'h0000_0000);
    // pulse a pin with the clock stopped
    run = 0;
    ack = 0;
    #20 ext_irq_in[3] = 1'b1;
    #20 ext_irq_in[3] = 1'b0;
    #20 check("latched", vector_irq_ctrl_req, 32'h0000_0008);
    check("woke", woke, 1'b1);
    run = 1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, EVR_OFS_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_0008);
    check("any_req", any_req, 1'b1);
    apb(1'b0, EVR_OFS_ROUTED, 32'h0000_0000);
    check("routed", rd, 32'h0000_0008);
    apb(1'b0, EVR_OFS_LEVEL, 32'h0000_0000);
    check("level", rd, 32'h0000_0000);
    apb(1'b0, EVR_OFS_TYPE, 32'h0000_0000);
    check("type_rd", rd, 32'h01FF_FFFF);
    apb(1'b1, EVR_OFS_IRQ_MASK, 32'h0000_0008);
    repeat (2) @(negedge ref_clk);
    check("irq_on", irq, 1'b1);
    apb(1'b1, EVR_OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(negedge ref_clk);
    check("irq_masked", irq, 1'b0);
    apb(1'b1, EVR_OFS_IRQ_MASK, 32'h0000_0008);
    apb(1'b1, EVR_OFS_STATUS, 32'h0000_0008);
    repeat (2) @(negedge ref_clk);
    check("cleared", {irq, vector_irq_ctrl_req}, 32'h0000_0000);
    summarize();
  end
endmodule : test_event_router
